// ---- tsi_dm_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsi_dm_model (
  // Data memory read port
  input wire logic [6:0] dmAddr,
  output logic [7:0] dmData
);
  // Byte tied to the address, so a wrong stream or channel shows up
  assign dmData = {1'b1, dmAddr} ^ 8'h5A;
endmodule // tsi_dm_model
`default_nettype wire

// ---- tsi_pkg.sv ----
// Summary of operation
// - Split access set: channel reads see data memory, writes go to connection low.
// - Split access clear: channel accesses reach the memory named by the target field.
// - The stream index picks the 32-location subsection of the chosen memory.
// - Processor-source set: every channel sends its low byte unless the global enable is low.
// - Processor-source clear: each channel's own entries decide its source and drive.
// - Target 01 is read-only data memory, 10 is connection low, 11 is connection high.
// - High entries keep only channel source and output enable; other bits read as 0.
// - Channel source set sends the low byte itself; clear uses it as a source address.
// - As an address, low bits 6-5 name the input stream and 4-0 the channel; bit 7 unused.
// - With channel source or processor-source set, low bits 6-0 are sent and bit 7 is always 0.
// - High bit 0 drives the channel when 1, floats it when 0, while global enable is high.
// - While the global output enable is low, every serial output channel is floated.
// - Processor-source set: every entry acts as if channel source and enable were set.
// - Register-space bit low reaches control; high lets five address bits pick one of 32.
`default_nettype none
package tsi_pkg;
  localparam int ENTRY_COUNT = 128;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hDB;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] LOW_RESET = 7'h00;
  localparam int HIGH_CS_BIT = 2;
  localparam int HIGH_OE_BIT = 0;

  typedef enum logic [1:0] {
    TSI_MT_RESERVED,
    TSI_MT_DATA,
    TSI_MT_CONN_LOW,
    TSI_MT_CONN_HIGH
  } tsi_target_t;

  typedef struct packed {
    logic splitAccessMode;
    logic allChannelsCpuSource;
    logic unusedHigh;
    tsi_target_t memoryTargetSelect;
    logic unusedLow;
    logic [1:0] streamIndexSelect;
  } tsi_ctrl_t;

  typedef struct packed {
    logic write;
    logic registerSpaceSelectBit;
    logic [4:0] channel;
    logic [7:0] data;
  } tsi_cpu_req_t;

  typedef struct packed {
    logic enable;
    logic cpuSource;
    logic [7:0] data;
    logic [1:0] srcStream;
    logic [4:0] srcChannel;
  } tsi_chan_out_t;
endpackage
`default_nettype wire

// ---- tsi_switch_config_registers.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsi_switch_config_registers (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Processor port
  input wire logic cpuReq,
  input wire tsi_pkg::tsi_cpu_req_t cpuCmd,
  output logic cpuAck,
  output logic [7:0] cpuRdData,
  // Data memory read port, owned by the serial receive side
  output logic [6:0] dmAddr,
  input wire logic [7:0] dmData,
  // Output channel lookup from the serial transmit side
  input wire logic queryValid,
  input wire logic [6:0] queryIndex,
  input wire logic globalOutputEnable,
  output tsi_pkg::tsi_chan_out_t chanOut,
  output logic chanDriveEn,
  // Control register view
  output tsi_pkg::tsi_ctrl_t switchControl
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  tsi_pkg::tsi_ctrl_t ctrl;
  logic [6:0] connLow [tsi_pkg::ENTRY_COUNT];
  logic [1:0] connHigh [tsi_pkg::ENTRY_COUNT];

  function automatic logic [6:0] entryIndex(input logic [1:0] stream, input logic [4:0] chan);
    entryIndex = {stream, chan};
  endfunction

  // ------------------------------------------------------------
  // Processor access decode
  // ------------------------------------------------------------
  wire logic ctrlAccess = cpuReq && !cpuCmd.registerSpaceSelectBit;
  wire logic chanAccess = cpuReq && cpuCmd.registerSpaceSelectBit;
  wire logic [6:0] cpuIndex = entryIndex(ctrl.streamIndexSelect, cpuCmd.channel);
  // Split mode overrides the target: reads see data memory, writes land in low
  wire tsi_pkg::tsi_target_t rdTarget =
    ctrl.splitAccessMode ? tsi_pkg::TSI_MT_DATA : ctrl.memoryTargetSelect;
  wire tsi_pkg::tsi_target_t wrTarget =
    ctrl.splitAccessMode ? tsi_pkg::TSI_MT_CONN_LOW : ctrl.memoryTargetSelect;
  wire logic lowWrite = chanAccess && cpuCmd.write && (wrTarget == tsi_pkg::TSI_MT_CONN_LOW);
  wire logic highWrite = chanAccess && cpuCmd.write && (wrTarget == tsi_pkg::TSI_MT_CONN_HIGH);
  wire logic [7:0] highRead = {5'h00, connHigh[cpuIndex][1], 1'b0, connHigh[cpuIndex][0]};
  wire logic [7:0] chanRead =
    (rdTarget == tsi_pkg::TSI_MT_DATA) ? dmData :
    (rdTarget == tsi_pkg::TSI_MT_CONN_LOW) ? {1'b0, connLow[cpuIndex]} :
    (rdTarget == tsi_pkg::TSI_MT_CONN_HIGH) ? highRead : 8'h00;
  wire logic [7:0] next_rdData = cpuCmd.registerSpaceSelectBit ? chanRead : ctrl;

  assign dmAddr = cpuIndex;
  assign switchControl = ctrl;

  // ------------------------------------------------------------
  // Control register and answer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= tsi_pkg::tsi_ctrl_t'(tsi_pkg::CTRL_RESET);
    end else if (ctrlAccess && cpuCmd.write) begin
      ctrl <= tsi_pkg::tsi_ctrl_t'(cpuCmd.data & tsi_pkg::CTRL_WRITE_MASK);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpuAck <= 1'b0;
      cpuRdData <= 8'h00;
    end else begin
      cpuAck <= cpuReq;
      if (cpuReq && !cpuCmd.write) begin
        cpuRdData <= next_rdData;
      end
    end
  end

  // ------------------------------------------------------------
  // Connection memories
  // ------------------------------------------------------------
  // High entries reset floated so no output fights a shared line at start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < tsi_pkg::ENTRY_COUNT; i++) begin
        connHigh[i] <= 2'h0;
      end
    end else if (highWrite) begin
      connHigh[cpuIndex] <= {cpuCmd.data[tsi_pkg::HIGH_CS_BIT],
                             cpuCmd.data[tsi_pkg::HIGH_OE_BIT]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < tsi_pkg::ENTRY_COUNT; i++) begin
        connLow[i] <= tsi_pkg::LOW_RESET;
      end
    end else if (lowWrite) begin
      connLow[cpuIndex] <= cpuCmd.data[6:0];
    end
  end

  // ------------------------------------------------------------
  // Output channel lookup
  // ------------------------------------------------------------
  wire logic [6:0] qLow = connLow[queryIndex];
  wire logic qCs = connHigh[queryIndex][1] || ctrl.allChannelsCpuSource;
  wire logic qOe = connHigh[queryIndex][0] || ctrl.allChannelsCpuSource;
  wire tsi_pkg::tsi_chan_out_t next_chanOut = '{
    enable: qOe,
    cpuSource: qCs,
    data: {1'b0, qLow},
    srcStream: qLow[6:5],
    srcChannel: qLow[4:0]
  };

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chanOut <= '0;
    end else if (queryValid) begin
      chanOut <= next_chanOut;
    end
  end

  // Global enable acts at once, not at the next lookup
  assign chanDriveEn = chanOut.enable && globalOutputEnable;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_split_write_low: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && cpuCmd.write && ctrl.splitAccessMode)
      |=> (connLow[$past(cpuIndex)] == $past(cpuCmd.data[6:0])))
    else $error("split write missed connection low");

  a_split_read_dm: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && !cpuCmd.write && ctrl.splitAccessMode)
      |=> (cpuAck && cpuRdData == $past(dmData)))
    else $error("split read not from data memory");

  a_high_read_zero: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && !cpuCmd.write && !ctrl.splitAccessMode
      && ctrl.memoryTargetSelect == tsi_pkg::TSI_MT_CONN_HIGH)
      |=> (cpuRdData[7:3] == 5'h00 && !cpuRdData[1]))
    else $error("connection high read shows unused bits");

  a_dm_read_only: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && cpuCmd.write && !ctrl.splitAccessMode
      && ctrl.memoryTargetSelect == tsi_pkg::TSI_MT_DATA)
      |=> (connLow[$past(cpuIndex)] == $past(connLow[cpuIndex])
        && connHigh[$past(cpuIndex)] == $past(connHigh[cpuIndex])))
    else $error("data memory target changed a connection entry");

  a_ctrl_unused: assert property (@(posedge clk) disable iff (rst)
    (ctrlAccess && cpuCmd.write) |=> (!ctrl.unusedHigh && !ctrl.unusedLow
      && ctrl.streamIndexSelect == $past(cpuCmd.data[1:0])))
    else $error("control write wrong");

  a_cpu_source_all: assert property (@(posedge clk) disable iff (rst)
    (queryValid && ctrl.allChannelsCpuSource)
      |=> (chanOut.cpuSource && chanOut.enable && chanOut.data == {1'b0, $past(qLow)}))
    else $error("processor source not forced");

  a_goe_low_float: assert property (@(posedge clk) disable iff (rst)
    !globalOutputEnable |-> !chanDriveEn)
    else $error("output driven while global enable low");

  a_source_address: assert property (@(posedge clk) disable iff (rst)
    (queryValid && !ctrl.allChannelsCpuSource && !connHigh[queryIndex][1])
      |=> (!chanOut.cpuSource && {chanOut.srcStream, chanOut.srcChannel}
        == $past(connLow[queryIndex])))
    else $error("source address wrong");

  a_entry_enable: assert property (@(posedge clk) disable iff (rst)
    (queryValid && !ctrl.allChannelsCpuSource) ##1 globalOutputEnable
      |-> (chanDriveEn == $past(connHigh[queryIndex][0])))
    else $error("per-channel enable wrong");

  a_plain_write_low: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && cpuCmd.write && !ctrl.splitAccessMode
      && ctrl.memoryTargetSelect == tsi_pkg::TSI_MT_CONN_LOW)
      |=> (connLow[$past(cpuIndex)] == $past(cpuCmd.data[6:0])))
    else $error("connection low write missed");

  a_plain_write_high: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && cpuCmd.write && !ctrl.splitAccessMode
      && ctrl.memoryTargetSelect == tsi_pkg::TSI_MT_CONN_HIGH)
      |=> (connHigh[$past(cpuIndex)] == {$past(cpuCmd.data[tsi_pkg::HIGH_CS_BIT]),
        $past(cpuCmd.data[tsi_pkg::HIGH_OE_BIT])}))
    else $error("connection high write missed");

  a_split_high_hold: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && cpuCmd.write && ctrl.splitAccessMode)
      |=> (connHigh[$past(cpuIndex)] == $past(connHigh[cpuIndex])))
    else $error("split write reached connection high");

  a_low_read_pad: assert property (@(posedge clk) disable iff (rst)
    (chanAccess && !cpuCmd.write && !ctrl.splitAccessMode
      && ctrl.memoryTargetSelect == tsi_pkg::TSI_MT_CONN_LOW)
      |=> (cpuRdData == {1'b0, $past(connLow[cpuIndex])}))
    else $error("connection low read wrong");

  a_ctrl_read_back: assert property (@(posedge clk) disable iff (rst)
    (ctrlAccess && !cpuCmd.write) |=> (cpuAck && cpuRdData == $past(ctrl)))
    else $error("control read wrong");

  a_ctrl_write_hold: assert property (@(posedge clk) disable iff (rst)
    (chanAccess || !cpuReq) |=> $stable(ctrl))
    else $error("control changed without a control write");

  a_entry_source_bit: assert property (@(posedge clk) disable iff (rst)
    (queryValid && !ctrl.allChannelsCpuSource)
      |=> (chanOut.cpuSource == $past(connHigh[queryIndex][1])))
    else $error("channel source bit not followed");

  a_entry_oe_bit: assert property (@(posedge clk) disable iff (rst)
    (queryValid && !ctrl.allChannelsCpuSource)
      |=> (chanOut.enable == $past(connHigh[queryIndex][0])))
    else $error("output enable bit not followed");

  a_lookup_byte: assert property (@(posedge clk) disable iff (rst)
    queryValid |=> (chanOut.data == {1'b0, $past(connLow[queryIndex])}))
    else $error("lookup byte wrong");
endmodule // tsi_switch_config_registers
`default_nettype wire

// ---- tsi_switch_config_registers_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsi_switch_config_registers_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cpuReq = 1'b0;
  tsi_pkg::tsi_cpu_req_t cpuCmd = '0;
  logic cpuAck;
  logic [7:0] cpuRdData;
  logic [6:0] dmAddr;
  logic [7:0] dmData;
  logic queryValid = 1'b0;
  logic [6:0] queryIndex = 7'h00;
  logic globalOutputEnable = 1'b1;
  tsi_pkg::tsi_chan_out_t chanOut;
  logic chanDriveEn;
  tsi_pkg::tsi_ctrl_t switchControl;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] rd;

  always #2.5 clk = ~clk;

  tsi_switch_config_registers u_dut (.clk(clk), .rst(rst), .cpuReq(cpuReq), .cpuCmd(cpuCmd),
    .cpuAck(cpuAck), .cpuRdData(cpuRdData), .dmAddr(dmAddr), .dmData(dmData),
    .queryValid(queryValid), .queryIndex(queryIndex), .globalOutputEnable(globalOutputEnable),
    .chanOut(chanOut), .chanDriveEn(chanDriveEn), .switchControl(switchControl));
  tsi_dm_model u_dm (.dmAddr(dmAddr), .dmData(dmData));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [7:0] dmExp(input logic [6:0] a);
    return {1'b1, a} ^ 8'h5A;
  endfunction

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ack is registered on the taking edge and checked 1 ns after it
  task automatic cpu(input logic wr, input logic chSpace, input logic [4:0] ch,
                     input logic [7:0] d);
    @(posedge clk);
    #1;
    cpuReq = 1'b1;
    cpuCmd = '{wr, chSpace, ch, d};
    @(posedge clk);
    #1;
    cpuReq = 1'b0;
    rd = cpuRdData;
    chk({7'h00, cpuAck}, 8'h01);
  endtask

  task automatic look(input logic [6:0] idx);
    @(posedge clk);
    #1;
    queryValid = 1'b1;
    queryIndex = idx;
    @(posedge clk);
    #1;
    queryValid = 1'b0;
  endtask

  // Drop the global enable on the launch offset, check, restore one cycle later
  task automatic goeLow();
    globalOutputEnable = 1'b0;
    #1;
    chk({7'h00, chanDriveEn}, 8'h00);
    @(posedge clk);
    #1;
    globalOutputEnable = 1'b1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic scenCtrl();
    cpu(1'b1, 1'b0, 5'h00, 8'hFF);
    cpu(1'b0, 1'b0, 5'h1F, 8'h00);
    chk(rd, 8'hDB);
    chk(switchControl, 8'hDB);
  endtask

  task automatic scenNormal();
    cpu(1'b1, 1'b0, 5'h00, 8'h12);
    cpu(1'b1, 1'b1, 5'h05, 8'hFF);
    cpu(1'b1, 1'b0, 5'h00, 8'h11);
    cpu(1'b1, 1'b1, 5'h05, 8'h11);
    cpu(1'b1, 1'b0, 5'h00, 8'h12);
    cpu(1'b0, 1'b1, 5'h05, 8'h00);
    chk(rd, 8'h7F);
    cpu(1'b1, 1'b0, 5'h00, 8'h1A);
    cpu(1'b1, 1'b1, 5'h05, 8'hFF);
    cpu(1'b0, 1'b1, 5'h05, 8'h00);
    chk(rd, 8'h05);
  endtask

  task automatic scenData();
    cpu(1'b1, 1'b0, 5'h00, 8'h0A);
    cpu(1'b1, 1'b1, 5'h05, 8'h00);
    cpu(1'b0, 1'b1, 5'h05, 8'h00);
    chk(rd, dmExp(7'h45));
    chk({1'b0, dmAddr}, 8'h45);
    cpu(1'b1, 1'b0, 5'h00, 8'h12);
    cpu(1'b0, 1'b1, 5'h05, 8'h00);
    chk(rd, 8'h7F);
  endtask

  task automatic scenSplit();
    cpu(1'b1, 1'b0, 5'h00, 8'h9A);
    cpu(1'b1, 1'b1, 5'h07, 8'h33);
    cpu(1'b0, 1'b1, 5'h07, 8'h00);
    chk(rd, dmExp(7'h47));
    cpu(1'b1, 1'b0, 5'h00, 8'h1A);
    cpu(1'b0, 1'b1, 5'h07, 8'h00);
    chk(rd, 8'h00);
    cpu(1'b1, 1'b0, 5'h00, 8'h12);
    cpu(1'b0, 1'b1, 5'h07, 8'h00);
    chk(rd, 8'h33);
  endtask

  task automatic scenLookup();
    look(7'h45);
    chk({chanOut.enable, chanOut.cpuSource, chanDriveEn, 5'h00}, 8'hE0);
    chk(chanOut.data, 8'h7F);
    goeLow();
    look(7'h47);
    chk({chanOut.enable, chanOut.cpuSource, chanDriveEn, chanOut.srcStream, 3'h0}, 8'h08);
    chk({3'h0, chanOut.srcChannel}, 8'h13);
    cpu(1'b1, 1'b0, 5'h00, 8'h52);
    look(7'h47);
    chk({chanOut.enable, chanOut.cpuSource, chanDriveEn, 5'h00}, 8'hE0);
    chk(chanOut.data, 8'h33);
    goeLow();
    cpu(1'b1, 1'b0, 5'h00, 8'h12);
    look(7'h47);
    chk({chanOut.enable, chanOut.cpuSource, 6'h00}, 8'h00);
  endtask

  initial begin
    #20000;
    num_errors++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    scenCtrl();
    scenNormal();
    scenData();
    scenSplit();
    scenLookup();
    conclude();
  end
endmodule // tsi_switch_config_registers_tb
`default_nettype wire
